// file: rtl/segmap_quad_ctl.v
// Quadrant decode and memory strobe selection for one physical address.
// Assumes rd and wr are never high together.
`timescale 1ns/1ps
`default_nettype none
`include "segmap_regs.vh"

module segmap_quad_ctl (
  input  wire [19:0] phys_in,
  input  wire [31:0] bank_flat,
  input  wire        rd,
  input  wire        wr,
  output reg  [19:0] phys_out,
  output reg  [2:0]  cs_n,
  output reg  [1:0]  oe_n,
  output reg  [1:0]  we_n,
  output wire [1:0]  quadrant,
  output wire        wr_blocked
);

  wire [7:0] bank;
  wire [1:0] cs_sel;
  wire       pair;
  wire       active;

  assign quadrant   = phys_in[19:18];
  assign bank       = bank_flat[{quadrant, 3'b000} +: 8];
  assign cs_sel     = bank[`SEGMAP_BK_CS_LSB +: 2];
  assign pair       = bank[`SEGMAP_BK_PAIR_BIT];
  assign active     = rd | wr;
  assign wr_blocked = wr & bank[`SEGMAP_BK_NOWR_BIT];

  always @*
  begin
    phys_out     = phys_in;
    phys_out[16] = phys_in[16] ^ bank[`SEGMAP_BK_INV_A16_BIT];
    phys_out[18] = phys_in[18] ^ bank[`SEGMAP_BK_INV_A18_BIT];
    phys_out[19] = phys_in[19] ^ bank[`SEGMAP_BK_INV_A19_BIT];
    cs_n = 3'b111;
    oe_n = 2'b11;
    we_n = 2'b11;
    if (active && cs_sel != 2'h3)
      cs_n[cs_sel] = 1'b0;
    if (rd)
      oe_n[pair] = 1'b0;
    if (wr && !bank[`SEGMAP_BK_NOWR_BIT])
      we_n[pair] = 1'b0;
  end

endmodule
`default_nettype wire

// file: rtl/segmap_regs.vh
// Register offsets, field positions, reset values and fixed constants of
// the segmented address mapper.
// Assumes inclusion by bare name from the mapper design files.
//
// Operation
// - Every 16-bit logical address from the core is turned into a 20-bit physical address.
// - The logical space has four zones, the root zone without a segment register and three zones with one each.
// - In a segmented zone the 8-bit segment value is added to logical bits 15:12 to form physical bits 19:12, and bits 11:0 pass through.
// - An 8-bit zone-size register holds two 4-bit fields, one per movable zone boundary.
// - Each movable boundary sits at the logical address whose upper nibble equals its field.
// - Only physical lines A16, A18 and A19 may be altered by the memory interface; all others pass unchanged.
// - The physical space is split into four 256K quadrants, and the quadrant picks the memory control setting.
// - Three active-low chip selects, two output enables and two write enables act like static memory control lines.
`ifndef SEGMAP_REGS_VH
`define SEGMAP_REGS_VH

// Avalon byte offsets.
`define SEGMAP_OFF_ZONE_SIZES   6'h00
`define SEGMAP_OFF_DATA_SEG     6'h04
`define SEGMAP_OFF_STACK_SEG    6'h08
`define SEGMAP_OFF_CODE_WINDOW  6'h0C
`define SEGMAP_OFF_BANK0        6'h10
`define SEGMAP_OFF_STATUS       6'h20
`define SEGMAP_BANK_STRIDE      6'h04

// Reset values.
`define SEGMAP_RST_ZONE_SIZES   8'hFF
`define SEGMAP_RST_SEGMENT      8'h00
`define SEGMAP_RST_BANK         8'h00

// Zone-size fields.
`define SEGMAP_ZS_FIRST_LSB     0
`define SEGMAP_ZS_SECOND_LSB    4

// Fixed start of the uppermost zone (upper logical nibble).
`define SEGMAP_TOP_ZONE_NIB     4'hE

// Zone codes.
`define SEGMAP_ZONE_ROOT        2'h0
`define SEGMAP_ZONE_DATA        2'h1
`define SEGMAP_ZONE_STACK       2'h2
`define SEGMAP_ZONE_CODE        2'h3

// Bank control fields.
`define SEGMAP_BK_CS_LSB        0
`define SEGMAP_BK_PAIR_BIT      2
`define SEGMAP_BK_NOWR_BIT      3
`define SEGMAP_BK_INV_A16_BIT   4
`define SEGMAP_BK_INV_A18_BIT   5
`define SEGMAP_BK_INV_A19_BIT   6

// Status fields.
`define SEGMAP_ST_ZONE_LSB      20
`define SEGMAP_ST_QUAD_LSB      22
`define SEGMAP_ST_BLOCKED_BIT   24

`endif

// file: rtl/segmap_top.v
// Segmented address mapper: zone mapping, memory interface strobes and
// an Avalon-MM register slave with waitrequest.
// Assumes core address and strobes are synchronous to clk, and the bus
// master holds each request until it sees waitrequest low.
//
// The Avalon-MM register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "segmap_regs.vh"

module segmap_top (
  input  wire        clk,
  input  wire        reset,
  // Register bus.
  input  wire [5:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [3:0]  avs_byteenable,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  // Processor core side.
  input  wire [15:0] core_addr,
  input  wire        core_rd,
  input  wire        core_wr,
  // External static memory side.
  output reg  [19:0] mem_addr,
  output reg         chip_select_zero_n,
  output reg         chip_select_one_n,
  output reg         chip_select_two_n,
  output reg         output_enable_zero_n,
  output reg         output_enable_one_n,
  output reg         write_enable_zero_n,
  output reg         write_enable_one_n
);

  // Register state.
  reg  [7:0]  zone_boundary_sizes_q;
  reg  [7:0]  data_seg_q;
  reg  [7:0]  stack_seg_q;
  reg  [7:0]  extended_code_window_q;
  wire [31:0] bank_flat;
  reg         blocked_q;
  reg  [1:0]  last_zone_q;
  reg  [1:0]  last_quad_q;
  reg  [19:0] last_phys_q;

  // Bus handshake state.
  reg         ack_q;
  wire        bus_req;
  wire        wr_take;
  wire        rd_take;
  wire        lane0;
  reg  [31:0] rdata_d;

  // Datapath.
  wire [19:0] mapped_addr;
  wire [1:0]  zone;
  wire [19:0] phys_out;
  wire [2:0]  cs_n;
  wire [1:0]  oe_n;
  wire [1:0]  we_n;
  wire [1:0]  quadrant;
  wire        wr_blocked;
  wire        access;
  wire        blocked_clear;

  // Every request waits exactly one cycle; the write lands and read data
  // is valid at the edge where waitrequest is low.
  assign bus_req         = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~ack_q;
  assign wr_take         = avs_write & ack_q;
  assign rd_take         = avs_read & ~ack_q;
  assign lane0           = avs_byteenable[0];

  always @(posedge clk or posedge reset)
  begin
    if (reset)
      ack_q <= 1'b0;
    else
      ack_q <= bus_req & ~ack_q;
  end

  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      zone_boundary_sizes_q  <= `SEGMAP_RST_ZONE_SIZES;
      data_seg_q             <= `SEGMAP_RST_SEGMENT;
      stack_seg_q            <= `SEGMAP_RST_SEGMENT;
      extended_code_window_q <= `SEGMAP_RST_SEGMENT;
    end
    else if (wr_take && lane0)
    begin
      if (avs_address == `SEGMAP_OFF_ZONE_SIZES)
        zone_boundary_sizes_q <= avs_writedata[7:0];
      else if (avs_address == `SEGMAP_OFF_DATA_SEG)
        data_seg_q <= avs_writedata[7:0];
      else if (avs_address == `SEGMAP_OFF_STACK_SEG)
        stack_seg_q <= avs_writedata[7:0];
      else if (avs_address == `SEGMAP_OFF_CODE_WINDOW)
        extended_code_window_q <= avs_writedata[7:0];
    end
  end

  // One bank control register per quadrant.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_bank
      reg  [7:0]  bank_q;
      wire [31:0] bank_sum;
      wire [5:0]  bank_off;
      // The offset sum is integer wide; only the six address bits matter.
      assign bank_sum = `SEGMAP_OFF_BANK0 + gi * `SEGMAP_BANK_STRIDE;
      assign bank_off = bank_sum[5:0];
      always @(posedge clk or posedge reset)
      begin
        if (reset)
          bank_q <= `SEGMAP_RST_BANK;
        else if (wr_take && lane0 && avs_address == bank_off)
          bank_q <= avs_writedata[7:0];
      end
      assign bank_flat[gi * 8 +: 8] = bank_q;
    end
  endgenerate

  // Read data is captured in the waiting cycle so that it stands at the
  // edge where the master takes it.
  always @*
  begin
    rdata_d = 32'h00000000;
    if (avs_address == `SEGMAP_OFF_ZONE_SIZES)
      rdata_d[7:0] = zone_boundary_sizes_q;
    else if (avs_address == `SEGMAP_OFF_DATA_SEG)
      rdata_d[7:0] = data_seg_q;
    else if (avs_address == `SEGMAP_OFF_STACK_SEG)
      rdata_d[7:0] = stack_seg_q;
    else if (avs_address == `SEGMAP_OFF_CODE_WINDOW)
      rdata_d[7:0] = extended_code_window_q;
    else if (avs_address == `SEGMAP_OFF_BANK0)
      rdata_d[7:0] = bank_flat[7:0];
    else if (avs_address == `SEGMAP_OFF_BANK0 + `SEGMAP_BANK_STRIDE)
      rdata_d[7:0] = bank_flat[15:8];
    else if (avs_address == `SEGMAP_OFF_BANK0 + 2 * `SEGMAP_BANK_STRIDE)
      rdata_d[7:0] = bank_flat[23:16];
    else if (avs_address == `SEGMAP_OFF_BANK0 + 3 * `SEGMAP_BANK_STRIDE)
      rdata_d[7:0] = bank_flat[31:24];
    else if (avs_address == `SEGMAP_OFF_STATUS)
    begin
      rdata_d[19:0] = last_phys_q;
      rdata_d[`SEGMAP_ST_ZONE_LSB +: 2] = last_zone_q;
      rdata_d[`SEGMAP_ST_QUAD_LSB +: 2] = last_quad_q;
      rdata_d[`SEGMAP_ST_BLOCKED_BIT]   = blocked_q;
    end
  end

  always @(posedge clk or posedge reset)
  begin
    if (reset)
      avs_readdata <= 32'h00000000;
    else if (rd_take)
      avs_readdata <= rdata_d;
  end

  segmap_zone_map u_zone_map (
    .logical_addr  (core_addr),
    .zone_sizes    (zone_boundary_sizes_q),
    .data_seg      (data_seg_q),
    .stack_seg     (stack_seg_q),
    .code_window   (extended_code_window_q),
    .physical_addr (mapped_addr),
    .zone          (zone)
  );

  segmap_quad_ctl u_quad_ctl (
    .phys_in    (mapped_addr),
    .bank_flat  (bank_flat),
    .rd         (core_rd),
    .wr         (core_wr),
    .phys_out   (phys_out),
    .cs_n       (cs_n),
    .oe_n       (oe_n),
    .we_n       (we_n),
    .quadrant   (quadrant),
    .wr_blocked (wr_blocked)
  );

  // Memory pins are registered: one cycle from core request to strobes.
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      mem_addr             <= 20'h00000;
      chip_select_zero_n   <= 1'b1;
      chip_select_one_n    <= 1'b1;
      chip_select_two_n    <= 1'b1;
      output_enable_zero_n <= 1'b1;
      output_enable_one_n  <= 1'b1;
      write_enable_zero_n  <= 1'b1;
      write_enable_one_n   <= 1'b1;
    end
    else
    begin
      mem_addr             <= phys_out;
      chip_select_zero_n   <= cs_n[0];
      chip_select_one_n    <= cs_n[1];
      chip_select_two_n    <= cs_n[2];
      output_enable_zero_n <= oe_n[0];
      output_enable_one_n  <= oe_n[1];
      write_enable_zero_n  <= we_n[0];
      write_enable_one_n   <= we_n[1];
    end
  end

  // Status capture of the most recent core access.
  assign access        = core_rd | core_wr;
  assign blocked_clear = wr_take && avs_address == `SEGMAP_OFF_STATUS &&
                         avs_byteenable[3] &&
                         avs_writedata[`SEGMAP_ST_BLOCKED_BIT];

  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      last_phys_q <= 20'h00000;
      last_zone_q <= `SEGMAP_ZONE_ROOT;
      last_quad_q <= 2'h0;
    end
    else if (access)
    begin
      last_phys_q <= phys_out;
      last_zone_q <= zone;
      last_quad_q <= quadrant;
    end
  end

  // A write into a quadrant without write enable is flagged; a new event
  // in the clearing cycle keeps the flag set.
  always @(posedge clk or posedge reset)
  begin
    if (reset)
      blocked_q <= 1'b0;
    else if (wr_blocked)
      blocked_q <= 1'b1;
    else if (blocked_clear)
      blocked_q <= 1'b0;
  end

endmodule
`default_nettype wire

// file: rtl/segmap_zone_map.v
// Logical to physical translation of one core address.
// Assumes the address and register values are stable in the clock cycle.
`timescale 1ns/1ps
`default_nettype none
`include "segmap_regs.vh"

module segmap_zone_map (
  input  wire [15:0] logical_addr,
  input  wire [7:0]  zone_sizes,
  input  wire [7:0]  data_seg,
  input  wire [7:0]  stack_seg,
  input  wire [7:0]  code_window,
  output reg  [19:0] physical_addr,
  output reg  [1:0]  zone
);

  wire [3:0] nib;
  wire [3:0] first_bound;
  wire [3:0] second_bound;
  reg  [7:0] offset;

  assign nib          = logical_addr[15:12];
  assign first_bound  = zone_sizes[`SEGMAP_ZS_FIRST_LSB +: 4];
  assign second_bound = zone_sizes[`SEGMAP_ZS_SECOND_LSB +: 4];

  always @*
  begin
    if (nib >= `SEGMAP_TOP_ZONE_NIB)
    begin
      zone   = `SEGMAP_ZONE_CODE;
      offset = code_window;
    end
    else if (nib >= second_bound)
    begin
      zone   = `SEGMAP_ZONE_STACK;
      offset = stack_seg;
    end
    else if (nib >= first_bound)
    begin
      zone   = `SEGMAP_ZONE_DATA;
      offset = data_seg;
    end
    else
    begin
      zone   = `SEGMAP_ZONE_ROOT;
      offset = 8'h00;
    end
    physical_addr[19:12] = offset + {4'h0, nib};
    physical_addr[11:0]  = logical_addr[11:0];
  end

endmodule
`default_nettype wire

// file: tb/segmap_asserts.sv
// Port checker for the segmented address mapper.
// Assumes it is bound to segmap_top by the bind after the module.
`timescale 1ns/1ps
`default_nettype none
module segmap_asserts (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic [5:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [15:0] core_addr,
  input wire logic        core_rd,
  input wire logic        core_wr,
  input wire logic [19:0] mem_addr,
  input wire logic        chip_select_zero_n,
  input wire logic        chip_select_one_n,
  input wire logic        chip_select_two_n,
  input wire logic        output_enable_zero_n,
  input wire logic        output_enable_one_n,
  input wire logic        write_enable_zero_n,
  input wire logic        write_enable_one_n
);
  wire [2:0] cs_n = {chip_select_two_n, chip_select_one_n,
                     chip_select_zero_n};
  wire [1:0] oe_n = {output_enable_one_n, output_enable_zero_n};
  wire [1:0] we_n = {write_enable_one_n, write_enable_zero_n};
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  sequence bus_wait;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence read_done;
    avs_read && !avs_waitrequest;
  endsequence
  bus_hold_a: assert property ($rose(avs_read || avs_write) |-> bus_wait)
    else $error("New request not held off.");
  bus_done_a: assert property (bus_wait |=> !avs_waitrequest)
    else $error("Request not answered in one cycle.");
  upper_zero_a: assert property ((read_done and avs_address < 6'h20) |->
    avs_readdata[31:8] == 24'h0) else $error("Upper read bits set.");
  unmapped_zero_a: assert property ((read_done and avs_address > 6'h23) |->
    avs_readdata == 32'h0) else $error("Unmapped read not zero.");
  one_strobe_a: assert property ($onehot0(~cs_n) && $onehot0(~oe_n) &&
    $onehot0(~we_n)) else $error("Two strobes of a kind low.");
  idle_high_a: assert property (!core_rd && !core_wr |=>
    &{cs_n, oe_n, we_n}) else $error("Strobe low without access.");
  read_no_we_a: assert property (core_rd |=> &we_n)
    else $error("Write enable on a read.");
  write_no_oe_a: assert property (core_wr |=> &oe_n)
    else $error("Output enable on a write.");
  low_bits_a: assert property ((core_rd || core_wr) |=>
    mem_addr[11:0] == $past(core_addr[11:0])) else $error("Low bits lost.");
endmodule
bind segmap_top segmap_asserts i_segmap_asserts (
  .clk(clk), .reset(reset), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .core_addr(core_addr), .core_rd(core_rd), .core_wr(core_wr),
  .mem_addr(mem_addr), .chip_select_zero_n(chip_select_zero_n),
  .chip_select_one_n(chip_select_one_n),
  .chip_select_two_n(chip_select_two_n),
  .output_enable_zero_n(output_enable_zero_n),
  .output_enable_one_n(output_enable_one_n),
  .write_enable_zero_n(write_enable_zero_n),
  .write_enable_one_n(write_enable_one_n)
);
`default_nettype wire

// file: tb/segmap_sram_model.sv
// Behavioural stand-in for the external static memory chips.
// Assumes the strobes come straight from the mapper's registered outputs.
`timescale 1ns/1ps
`default_nettype none
module segmap_sram_model (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [2:0] cs_n,
  input  wire logic [1:0] we_n,
  output var  int         write_count
);
  // A chip takes a write only while it is selected and a write enable is low.
  always @(posedge clk or posedge reset)
    if (reset)
      write_count <= 0;
    else if (!(&cs_n) && !(&we_n))
      write_count <= write_count + 1;
endmodule
`default_nettype wire

// file: tb/test_segmap_top.sv
// Self-checking bench for the segmented address mapper.
// Assumes segmap_top, its checker and the memory model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_segmap_top;
  logic        clk = 0;
  logic        reset = 1;
  logic [5:0]  avs_address = 6'h00;
  logic        avs_read = 0;
  logic        avs_write = 0;
  logic [3:0]  avs_byteenable = 4'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [15:0] core_addr = 16'h0;
  logic        core_rd = 0;
  logic        core_wr = 0;
  logic [19:0] mem_addr;
  logic [2:0]  cs_n;
  logic [1:0]  oe_n;
  logic [1:0]  we_n;
  logic [31:0] rd_val;
  logic [31:0] r;
  logic [7:0]  zs = 8'hFF;
  logic [7:0]  sg [4] = '{default: 8'h00};
  logic [7:0]  bk [4] = '{default: 8'h00};
  logic [4:0]  st = 5'h00;
  int          bad_count = 0;
  int          checked = 0;
  int          exp_w = 0;
  int          wcount;
  int          seed = 32'h938F31E8;

  always #12.5 clk = ~clk;

  segmap_top i_segmap_top (
    .clk(clk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .core_addr(core_addr), .core_rd(core_rd), .core_wr(core_wr),
    .mem_addr(mem_addr), .chip_select_zero_n(cs_n[0]),
    .chip_select_one_n(cs_n[1]), .chip_select_two_n(cs_n[2]),
    .output_enable_zero_n(oe_n[0]), .output_enable_one_n(oe_n[1]),
    .write_enable_zero_n(we_n[0]), .write_enable_one_n(we_n[1])
  );
  segmap_sram_model i_segmap_sram_model (
    .clk(clk), .reset(reset), .cs_n(cs_n), .we_n(we_n),
    .write_count(wcount)
  );

  task check_val(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task complete_run;
    if (bad_count == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // The request is sampled against waitrequest as it stands before each edge.
  task bus(input logic w, input logic [5:0] a, input logic [31:0] d,
           input logic [3:0] be);
    @(posedge clk);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    @(negedge clk);
    while (avs_waitrequest !== 1'b0)
      @(negedge clk);
    @(posedge clk);
    rd_val = avs_readdata;
    avs_write <= 0;
    avs_read <= 0;
  endtask

  task wreg(input logic [5:0] a, input logic [7:0] d);
    if (a >= 6'h10)
      d[7] = 0;
    bus(1, a, {24'h0, d}, 4'h1);
    if (a == 6'h00)
      zs = d;
    else if (a < 6'h10)
      sg[a[3:2]] = d;
    else
      bk[a[3:2]] = d;
  endtask

  function logic [31:0] exp_reg(input logic [5:0] a);
    if (a == 6'h00)
      return zs;
    if (a < 6'h10)
      return sg[a[3:2]];
    if (a < 6'h20)
      return bk[a[3:2]];
    return 0;
  endfunction

  task core(input logic [15:0] a, input logic rd, input logic wr);
    logic [1:0]  z;
    logic [19:0] pa;
    logic [7:0]  b;
    logic [2:0]  ec;
    logic [1:0]  eo;
    logic [1:0]  ew;
    @(posedge clk);
    core_addr <= a;
    core_rd <= rd;
    core_wr <= wr;
    z = a[15:12] >= 4'hE ? 2'h3 : a[15:12] >= zs[7:4] ? 2'h2 :
        a[15:12] >= zs[3:0] ? 2'h1 : 2'h0;
    pa = {sg[z] + a[15:12], a[11:0]};
    b = bk[pa[19:18]];
    if (rd | wr)
      st = {wr & b[3] | st[4], pa[19:18], z};
    pa = pa ^ {b[6], b[5], 1'b0, b[4], 16'h0};
    ec = 3'h7;
    eo = 2'h3;
    ew = 2'h3;
    if ((rd | wr) && b[1:0] != 2'h3)
      ec[b[1:0]] = 0;
    if (rd)
      eo[b[2]] = 0;
    if (wr && !b[3])
      ew[b[2]] = 0;
    if (wr && !b[3] && b[1:0] != 2'h3)
      exp_w += 2;
    // Memory pins are registered, so the mapped access shows after c1.
    @(posedge clk);
    @(negedge clk);
    if (rd | wr)
      check_val(mem_addr, pa);
    check_val(cs_n, ec);
    check_val({oe_n, we_n}, {eo, ew});
    @(posedge clk);
    core_rd <= 0;
    core_wr <= 0;
  endtask

  initial
  begin
    repeat (16) @(posedge clk);
    reset <= 0;
    for (int a = 0; a < 40; a += 4)
    begin
      bus(0, a[5:0], 0, 4'hF);
      check_val(rd_val, exp_reg(a[5:0]));
    end
    repeat (60)
    begin
      r = $random(seed);
      wreg({r[2:0], 2'h0}, r[15:8]);
      bus(1, 6'h00, {24'h0, r[23:16]}, 4'h2);
      bus(0, {r[2:0], 2'h0}, 0, 4'hF);
      check_val(rd_val, exp_reg({r[2:0], 2'h0}));
      repeat (6)
      begin
        r = $random(seed);
        core(r[15:0], r[16], r[17] & !r[16]);
      end
      bus(0, 6'h20, 0, 4'hF);
      check_val(rd_val[24:20], st);
      if (r[18])
      begin
        bus(1, 6'h20, 32'h0100_0000, 4'h8);
        st[4] = 0;
      end
    end
    repeat (4) @(posedge clk);
    check_val(wcount, exp_w);
    complete_run;
  end

  initial
  begin
    #2000000;
    bad_count++;
    complete_run;
  end
endmodule
`default_nettype wire
